//--- fbl_pkg.sv
// Purpose: constants and types for the flash block latch writer
// Assumes: 8-bit register port, 14-bit flash words, 250 MHz clock
// Notes: register offsets are word indexes on the plain register port
`default_nettype none
package fbl_pkg;
	// Register offsets
	localparam logic [2:0] FBL_OFS_DATA_LO = 3'h0;
	localparam logic [2:0] FBL_OFS_DATA_HI = 3'h1;
	localparam logic [2:0] FBL_OFS_ADDR_LO = 3'h2;
	localparam logic [2:0] FBL_OFS_ADDR_HI = 3'h3;
	localparam logic [2:0] FBL_OFS_CTRL = 3'h4;
	localparam logic [2:0] FBL_OFS_KEY = 3'h5;
	// Control register bit positions
	localparam int FBL_BIT_PGM_SEL = 7;
	localparam int FBL_BIT_CFG_SEL = 6;
	localparam int FBL_BIT_LATCH_ONLY = 5;
	localparam int FBL_BIT_ERASE = 4;
	localparam int FBL_BIT_PERMIT = 2;
	localparam int FBL_BIT_GO = 1;
	// Unlock keys
	localparam logic [7:0] FBL_KEY_FIRST = 8'h55;
	localparam logic [7:0] FBL_KEY_SECOND = 8'haa;
	// Reset and fill values
	localparam logic [13:0] FBL_LATCH_BLANK = 14'h3fff;
	localparam logic [7:0] FBL_ADDR_HI_PAD = 8'h80;
	localparam logic [7:0] FBL_RST_BYTE = 8'h00;
	// Geometry
	localparam int FBL_NUM_LATCHES = 16;
	localparam int FBL_IDX_W = 4;
	// Timing
	localparam int FBL_CLK_MHZ = 250;
	localparam int FBL_PROG_TIME_US = 2000;
	localparam int FBL_PROG_CYCLES = FBL_PROG_TIME_US * FBL_CLK_MHZ;
	localparam int FBL_SETUP_CYCLES = 2;

	typedef enum logic [1:0] {
		FBL_ST_IDLE = 2'b00,
		FBL_ST_SETUP = 2'b01,
		FBL_ST_BUSY = 2'b10
	} fbl_state_t;

	typedef enum logic [1:0] {
		FBL_KEY_NONE = 2'b00,
		FBL_KEY_GOT1 = 2'b01,
		FBL_KEY_ARMED = 2'b10
	} fbl_key_t;

	// Operation presented to the flash array while busy
	typedef struct packed {
		logic prog;
		logic erase;
		logic [14:0] base;
	} fbl_flash_op_t;
endpackage
`default_nettype wire

//--- fbl_writer.sv
// Purpose: self-programming sequencer loading a 16-word latch block and committing it to program flash
// Assumes: CPU drives the register port on clk; flash array acts on flash_op_q while it is valid
// Notes: data EEPROM, configuration space and the error flag are not handled here
`default_nettype none
module fbl_writer
	import fbl_pkg::*;
#(
	parameter int PROG_CYCLES = FBL_PROG_CYCLES,
	parameter int SETUP_CYCLES = FBL_SETUP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	// CPU hold
	output logic cpu_stall_q,
	// Flash array
	output fbl_flash_op_t flash_op_q,
	output logic [FBL_NUM_LATCHES-1:0][13:0] latch_q
);

	////////////////////////////////////////////////////////////////////////
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);
	localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
	localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYCLES - 1);

	logic [7:0] data_lo_q, data_lo_d, data_hi_q, data_hi_d;
	logic [7:0] addr_lo_q, addr_lo_d;
	logic [6:0] addr_hi_q, addr_hi_d;
	logic pgm_sel_q, pgm_sel_d, cfg_sel_q, cfg_sel_d;
	logic latch_only_q, latch_only_d, erase_q, erase_d;
	logic permit_q, permit_d, go_q, go_d;
	logic commit_q, commit_d;
	fbl_key_t key_q, key_d;
	fbl_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [FBL_NUM_LATCHES-1:0][13:0] latch_d;
	logic [7:0] rdata_d;
	logic stall_d;
	fbl_flash_op_t op_d;
	logic wr_ctrl, go_req, start;

	// Row base: low address bits cleared to the block boundary
	function automatic logic [14:0] block_base(input logic [6:0] hi, input logic [7:0] lo);
		block_base = {hi, lo[7:FBL_IDX_W], {FBL_IDX_W{1'b0}}};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register writes and unlock detector
	always_comb begin
		data_lo_d = data_lo_q;
		data_hi_d = data_hi_q;
		addr_lo_d = addr_lo_q;
		addr_hi_d = addr_hi_q;
		pgm_sel_d = pgm_sel_q;
		cfg_sel_d = cfg_sel_q;
		latch_only_d = latch_only_q;
		erase_d = erase_q;
		permit_d = permit_q;
		key_d = key_q;
		wr_ctrl = reg_wr && reg_addr == FBL_OFS_CTRL;
		go_req = wr_ctrl && reg_wdata[FBL_BIT_GO];
		// Only a go in the armed state with permit set and program space starts anything
		start = go_req && key_q == FBL_KEY_ARMED && permit_q && pgm_sel_q && !cfg_sel_q
			&& st_q == FBL_ST_IDLE;
		if (reg_wr && st_q == FBL_ST_IDLE) begin
			unique case (reg_addr)
				FBL_OFS_DATA_LO: data_lo_d = reg_wdata;
				FBL_OFS_DATA_HI: data_hi_d = {2'b00, reg_wdata[5:0]};
				FBL_OFS_ADDR_LO: addr_lo_d = reg_wdata;
				FBL_OFS_ADDR_HI: addr_hi_d = reg_wdata[6:0];
				FBL_OFS_CTRL: begin
					pgm_sel_d = reg_wdata[FBL_BIT_PGM_SEL];
					cfg_sel_d = reg_wdata[FBL_BIT_CFG_SEL];
					latch_only_d = reg_wdata[FBL_BIT_LATCH_ONLY];
					erase_d = reg_wdata[FBL_BIT_ERASE];
					permit_d = reg_wdata[FBL_BIT_PERMIT];
				end
				default: ;
			endcase
		end
		// Any write that is not the next step or a first key drops the sequence; a first key restarts it
		if (reg_wr) begin
			if (reg_addr == FBL_OFS_KEY) begin
				if (key_q == FBL_KEY_NONE && reg_wdata == FBL_KEY_FIRST) begin
					key_d = FBL_KEY_GOT1;
				end else if (key_q == FBL_KEY_GOT1 && reg_wdata == FBL_KEY_SECOND) begin
					key_d = FBL_KEY_ARMED;
				end else if (reg_wdata == FBL_KEY_FIRST) begin
					key_d = FBL_KEY_GOT1;
				end else begin
					key_d = FBL_KEY_NONE;
				end
			end else begin
				key_d = FBL_KEY_NONE;
			end
		end
		// Erase bit clears itself once the erase is over
		if (st_q == FBL_ST_BUSY && cnt_q == PROG_LAST && flash_op_q.erase) begin
			erase_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_lo_q <= FBL_RST_BYTE;
			data_hi_q <= FBL_RST_BYTE;
			addr_lo_q <= FBL_RST_BYTE;
			addr_hi_q <= 7'h00;
			pgm_sel_q <= 1'b0;
			cfg_sel_q <= 1'b0;
			latch_only_q <= 1'b0;
			erase_q <= 1'b0;
			permit_q <= 1'b0;
			key_q <= FBL_KEY_NONE;
		end else begin
			data_lo_q <= data_lo_d;
			data_hi_q <= data_hi_d;
			addr_lo_q <= addr_lo_d;
			addr_hi_q <= addr_hi_d;
			pgm_sel_q <= pgm_sel_d;
			cfg_sel_q <= cfg_sel_d;
			latch_only_q <= latch_only_d;
			erase_q <= erase_d;
			permit_q <= permit_d;
			key_q <= key_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer, latches and flash operation
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		go_d = go_q;
		commit_d = commit_q;
		latch_d = latch_q;
		op_d = flash_op_q;
		stall_d = 1'b0;
		unique case (st_q)
			FBL_ST_IDLE: begin
				if (start) begin
					go_d = 1'b1;
					st_d = FBL_ST_SETUP;
					cnt_d = '0;
					stall_d = 1'b1;
					commit_d = erase_q || !latch_only_q;
					if (!erase_q) begin
						// Word goes to the latch picked by the low address bits only
						latch_d[addr_lo_q[FBL_IDX_W-1:0]] = {data_hi_q[5:0], data_lo_q};
					end
				end
			end
			FBL_ST_SETUP: begin
				stall_d = 1'b1;
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == SETUP_LAST) begin
					cnt_d = '0;
					if (commit_q) begin
						st_d = FBL_ST_BUSY;
						op_d.prog = !erase_q;
						op_d.erase = erase_q;
						op_d.base = block_base(addr_hi_q, addr_lo_q);
					end else begin
						// Latch-only load ends after setup without a hold
						st_d = FBL_ST_IDLE;
						go_d = 1'b0;
						stall_d = 1'b0;
					end
				end
			end
			FBL_ST_BUSY: begin
				stall_d = 1'b1;
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == PROG_LAST) begin
					st_d = FBL_ST_IDLE;
					cnt_d = '0;
					go_d = 1'b0;
					stall_d = 1'b0;
					op_d.prog = 1'b0;
					op_d.erase = 1'b0;
					if (flash_op_q.prog) begin
						latch_d = {FBL_NUM_LATCHES{FBL_LATCH_BLANK}};
					end
				end
			end
			default: begin
				st_d = FBL_ST_IDLE;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= FBL_ST_IDLE;
			cnt_q <= '0;
			go_q <= 1'b0;
			commit_q <= 1'b0;
			latch_q <= {FBL_NUM_LATCHES{FBL_LATCH_BLANK}};
			flash_op_q <= '0;
			cpu_stall_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			go_q <= go_d;
			commit_q <= commit_d;
			latch_q <= latch_d;
			flash_op_q <= op_d;
			cpu_stall_q <= stall_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; unmapped and key read zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				FBL_OFS_DATA_LO: rdata_d = data_lo_q;
				FBL_OFS_DATA_HI: rdata_d = data_hi_q;
				FBL_OFS_ADDR_LO: rdata_d = addr_lo_q;
				FBL_OFS_ADDR_HI: rdata_d = FBL_ADDR_HI_PAD | {1'b0, addr_hi_q};
				FBL_OFS_CTRL: begin
					rdata_d[FBL_BIT_PGM_SEL] = pgm_sel_q;
					rdata_d[FBL_BIT_CFG_SEL] = cfg_sel_q;
					rdata_d[FBL_BIT_LATCH_ONLY] = latch_only_q;
					rdata_d[FBL_BIT_ERASE] = erase_q;
					rdata_d[FBL_BIT_PERMIT] = permit_q;
					rdata_d[FBL_BIT_GO] = go_q;
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= rdata_d;
		end
	end

endmodule
`default_nettype wire

//--- fbl_writer_assertions.sv
// Purpose: port checks for the flash block latch writer
// Assumes: one clock, synchronous active-high reset
// Notes: program length is counted by helper logic, too long to unroll
`default_nettype none
module fbl_writer_chk
	import fbl_pkg::*;
#(
	parameter int PROG_CYCLES = FBL_PROG_CYCLES
) (
	// Watched ports
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic cpu_stall_q,
	input wire fbl_flash_op_t flash_op_q,
	input wire logic [FBL_NUM_LATCHES-1:0][13:0] latch_q
);
	logic [19:0] cnt_q;
	logic [19:0] cnt_d;
	always_comb cnt_d = flash_op_q.prog ? cnt_q + 20'h1 : 20'h0;
	always_ff @(posedge clk) cnt_q <= sys_rst ? 20'h0 : cnt_d;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////
	property p_no_erase; flash_op_q.prog |-> !flash_op_q.erase; endproperty
	a_no_erase: assert property (p_no_erase) else $error("erase during program");
	property p_aligned; $rose(flash_op_q.prog) |-> flash_op_q.base[3:0] == 4'h0; endproperty
	a_aligned: assert property (p_aligned) else $error("base not aligned");
	property p_blank; $fell(flash_op_q.prog) |-> latch_q == {FBL_NUM_LATCHES{FBL_LATCH_BLANK}}; endproperty
	a_blank: assert property (p_blank) else $error("latches not blank");
	property p_setup;
		$rose(cpu_stall_q) |-> cpu_stall_q ##1 cpu_stall_q ##1
			(cpu_stall_q == (flash_op_q.prog | flash_op_q.erase));
	endproperty
	a_setup: assert property (p_setup) else $error("bad setup stall");
	property p_start; $rose(flash_op_q.prog) |-> $past(cpu_stall_q, 2) && !$past(cpu_stall_q, 3); endproperty
	a_start: assert property (p_start) else $error("program start late");
	property p_len; $fell(flash_op_q.prog) |-> cnt_q == 20'(PROG_CYCLES); endproperty
	a_len: assert property (p_len) else $error("program time wrong");
	property p_resume; $fell(flash_op_q.prog) |-> $fell(cpu_stall_q); endproperty
	a_resume: assert property (p_resume) else $error("stall not released");
	property p_go_read; reg_rd && reg_addr == FBL_OFS_CTRL |=> reg_rdata_q[FBL_BIT_GO] == $past(cpu_stall_q); endproperty
	a_go_read: assert property (p_go_read) else $error("go bit mismatch");
	property p_go_cause;
		$rose(cpu_stall_q) |-> $past(reg_wr && reg_addr == FBL_OFS_CTRL && reg_wdata[FBL_BIT_GO]);
	endproperty
	a_go_cause: assert property (p_go_cause) else $error("stall without go");
	property p_erase_row;
		$rose(flash_op_q.erase) |-> flash_op_q.base[3:0] == 4'h0 && $stable(latch_q);
	endproperty
	a_erase_row: assert property (p_erase_row) else $error("erase not a whole row");
	c_erase: cover property ($rose(flash_op_q.erase));
	c_load: cover property ($fell(cpu_stall_q) && !$past(flash_op_q.prog));
	c_commit: cover property ($rose(flash_op_q.prog));
	c_read: cover property (reg_rd && reg_addr == FBL_OFS_CTRL);
endmodule
bind fbl_writer fbl_writer_chk #(.PROG_CYCLES(PROG_CYCLES)) u_fbl_writer_chk (.clk(clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.cpu_stall_q(cpu_stall_q), .flash_op_q(flash_op_q), .latch_q(latch_q));
`default_nettype wire

//--- test_fbl_writer.sv
// Purpose: register-level bench for the flash block latch writer
// Assumes: program time shortened to PC cycles
// Notes: stall length is counted from the cycle after the go write
`default_nettype none
module test_fbl_writer
	import fbl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PC = 20;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata_q;
	logic cpu_stall_q;
	fbl_flash_op_t flash_op_q;
	logic [FBL_NUM_LATCHES-1:0][13:0] latch_q;
	logic [13:0] exp_l [FBL_NUM_LATCHES];
	int n_mismatch = 0;
	int n_compared = 0;
	always #2 clk = ~clk;
	fbl_writer #(.PROG_CYCLES(PC)) u_fbl_writer (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.cpu_stall_q(cpu_stall_q), .flash_op_q(flash_op_q), .latch_q(latch_q));
	////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata_q}, {8'h00, e});
	endtask
	// Full unlock then go; counts stall cycles, checks the op in the third
	task automatic go(input logic [7:0] c, input int exp_n, input logic [14:0] base);
		int n;
		logic [1:0] op_e;
		n = 0;
		// Long holds are a program unless the erase bit rides along
		op_e = {exp_n > 2 && !c[FBL_BIT_ERASE], exp_n > 2 && c[FBL_BIT_ERASE]};
		wr(FBL_OFS_KEY, FBL_KEY_FIRST);
		wr(FBL_OFS_KEY, FBL_KEY_SECOND);
		wr(FBL_OFS_CTRL, c);
		#1;
		while (cpu_stall_q === 1'b1 && n < 100) begin
			n++;
			if (n == 3) begin
				chk({14'h0, flash_op_q.prog, flash_op_q.erase}, {14'h0, op_e});
				chk({1'b0, flash_op_q.base}, {1'b0, base});
			end
			@(posedge clk);
			#1;
		end
		if (n >= 100) begin
			n_mismatch++;
			stop_test();
		end
		chk(16'(n), 16'(exp_n));
	endtask
	task automatic chk_latches();
		for (int i = 0; i < FBL_NUM_LATCHES; i++) begin
			chk({2'b00, latch_q[i]}, {2'b00, exp_l[i]});
		end
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < FBL_NUM_LATCHES; i++) exp_l[i] = FBL_LATCH_BLANK;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk_latches();
		rd(FBL_OFS_ADDR_HI, FBL_ADDR_HI_PAD);
		rd(FBL_OFS_KEY, 8'h00);
		rd(3'h6, 8'h00);
		// Latch-only load into latch 3
		wr(FBL_OFS_ADDR_LO, 8'h13);
		wr(FBL_OFS_ADDR_HI, 8'h01);
		wr(FBL_OFS_DATA_LO, 8'hbc);
		wr(FBL_OFS_DATA_HI, 8'h2a);
		wr(FBL_OFS_CTRL, 8'ha4);
		go(8'ha6, 2, 15'h0);
		chk({15'h0, flash_op_q.prog}, 16'h0);
		exp_l[3] = 14'h2abc;
		chk_latches();
		rd(FBL_OFS_CTRL, 8'ha4);
		// A data write between the keys must disarm the unlock
		wr(FBL_OFS_KEY, FBL_KEY_FIRST);
		wr(FBL_OFS_DATA_LO, 8'h23);
		wr(FBL_OFS_KEY, FBL_KEY_SECOND);
		wr(FBL_OFS_CTRL, 8'ha6);
		#1;
		chk({15'h0, cpu_stall_q}, 16'h0);
		rd(FBL_OFS_CTRL, 8'ha4);
		// Permit clear refuses the go
		wr(FBL_OFS_CTRL, 8'ha0);
		go(8'ha2, 0, 15'h0);
		chk_latches();
		// Row erase before reprogramming: latches stay, erase bit self-clears
		wr(FBL_OFS_CTRL, 8'h94);
		go(8'h96, FBL_SETUP_CYCLES + PC, 15'h0110);
		chk_latches();
		rd(FBL_OFS_CTRL, 8'h84);
		// Commit from latch 4: whole block goes, latches blank after
		wr(FBL_OFS_DATA_HI, 8'h01);
		wr(FBL_OFS_ADDR_LO, 8'h14);
		wr(FBL_OFS_CTRL, 8'h84);
		go(8'h86, FBL_SETUP_CYCLES + PC, 15'h0110);
		exp_l[3] = FBL_LATCH_BLANK;
		chk_latches();
		rd(FBL_OFS_CTRL, 8'h84);
		stop_test();
	end
endmodule
`default_nettype wire
